// >>> design/tpc_map.svh
`ifndef TPC_MAP_SVH
`define TPC_MAP_SVH

// Register byte offsets
`define TPC_OFS_POS 8'h00
`define TPC_OFS_CTRL 8'h04
`define TPC_OFS_STAT 8'h08
`define TPC_OFS_CLR 8'h0C
`define TPC_OFS_EN 8'h10
`define TPC_OFS_REV 8'h14

// Control register fields
`define TPC_CTRL_FREEZE 0
`define TPC_CTRL_RST 1'h0

// Event bit positions in status, clear and enable
`define TPC_EV_STEP 0
`define TPC_EV_CARRY 1
`define TPC_EV_DIR 2
`define TPC_EV_RST 3'h0

// Reset values
`define TPC_POS_RST 16'h0000
`define TPC_DIR_RST 1'h1

// Timing, figures in ns, counts in clock cycles
`define TPC_CLK_NS 40
`define TPC_BUSY_NS 120
`define TPC_BUSY_CYC ((`TPC_BUSY_NS + `TPC_CLK_NS - 1) / `TPC_CLK_NS)
`define TPC_CARRY_NS 80
`define TPC_CARRY_CYC ((`TPC_CARRY_NS + `TPC_CLK_NS - 1) / `TPC_CLK_NS)
`define TPC_VALID_NS 490
`define TPC_VALID_CYC (`TPC_VALID_NS / `TPC_CLK_NS)

`endif

// >>> design/tpc_pkg.sv
package tpc_pkg;

  // Step sequencer states, one-hot
  typedef enum logic [2:0] {
    tpc_st_idle = 3'h1,
    tpc_st_busy = 3'h2,
    tpc_st_gap = 3'h4
  } tpc_state_t;

  // Resolution select code {hi, lo}
  typedef enum logic [1:0] {
    tpc_res_10 = 2'h0,
    tpc_res_12 = 2'h1,
    tpc_res_14 = 2'h2,
    tpc_res_16 = 2'h3
  } tpc_res_t;

endpackage : tpc_pkg

// >>> design/tpc_pulse_gen.sv
`timescale 1ns/1ns

// Fixed-width pulse from a one-cycle trigger; retrigger restarts it
module tpc_pulse_gen #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic trig,
  output logic pulse
);

  logic [3:0] left_q; // Cycles still to run
  logic [3:0] left_d;

  // Load on trigger, else count down to zero
  assign left_d = trig ? 4'(WIDTH) :
                  (left_q != 4'h0) ? left_q - 4'h1 : 4'h0;

  // Output is a flop so it is glitch free at the pin
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      left_q <= 4'h0;
      pulse <= 1'b0;
    end else begin
      left_q <= left_d;
      pulse <= (left_d != 4'h0);
    end
  end

endmodule : tpc_pulse_gen

// >>> design/tpc_irq_bank.sv
`timescale 1ns/1ns
`include "tpc_map.svh"

// Sticky event status; a set in the clearing cycle survives
module tpc_irq_bank (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [2:0] event_set,
  input wire logic [2:0] event_clr,
  output logic [2:0] status
);

  logic [2:0] status_d;

  // Set wins over clear so no event is lost
  assign status_d = (status & ~event_clr) | event_set;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      status <= `TPC_EV_RST;
    end else begin
      status <= status_d;
    end
  end

endmodule : tpc_irq_bank

// >>> design/tpc_position_counter.sv
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`include "tpc_map.svh"

//////////////////////////////////////////////////////////////////////////////
// Operation
// - Two select pins pick 10/12/14/16 bits
// - Counts follow input steps, no start command
// - One busy pulse per counted step
// - Position word is unsigned natural binary
// - Carry pulse on all-ones/all-zeros wrap
// - Direction settles before any carry pulse
// - Direction latched, changes only on reversal
// - Carry and direction ignore the freeze
// - Low inhibit freezes the output latch
// - Data flagged invalid while busy high
// - Counter moves by one per step
// - Latched data valid by 490 ns
module tpc_position_counter
  import tpc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic step_up,
  input wire logic step_down,
  input wire logic resolution_select_lo,
  input wire logic resolution_select_hi,
  input wire logic inhibit_b,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic [15:0] position_word,
  output logic busy,
  output logic data_valid,
  output logic step_ready,
  output logic direction,
  output logic revolution_carry_out,
  output logic latch_ready,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  tpc_res_t res_w; // Resolution code from the pins
  logic [15:0] mask_d; // Count mask for the pin code
  logic [15:0] mask_q; // Mask the counter obeys now
  logic [15:0] cnt_q; // Live position counter
  logic [15:0] cnt_d;
  logic [15:0] cnt_step; // Counter after a possible step
  logic step_ok; // A step taken this cycle
  logic wrap_w; // Step crosses all-ones/all-zeros
  logic carry_req_q; // Wrap, delayed behind direction
  logic dir_d;
  logic dir_flip; // Step opposes latched direction
  logic [15:0] rev_q; // Signed revolution tally
  logic [15:0] rev_d;
  tpc_state_t state_q;
  tpc_state_t state_d;
  logic [1:0] left_q; // Busy cycles still to run
  logic [1:0] left_d;
  logic freeze_w; // Output latch held
  logic [3:0] vcnt_q; // Cycles spent frozen
  logic [3:0] vcnt_d;
  logic ctrl_freeze_q; // Software freeze bit
  logic [2:0] en_q; // Interrupt enables
  logic [2:0] status_w; // Sticky event status
  logic [2:0] ev_w; // Events this cycle
  logic wr_ctrl;
  logic wr_clr;
  logic wr_en;
  logic [2:0] clr_w;
  logic [31:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Resolution and counting

  // Pins map straight to a mask; no start command exists
  assign res_w = tpc_res_t'({resolution_select_hi, resolution_select_lo});
  assign mask_d = (res_w == tpc_res_10) ? 16'h03FF :
                  (res_w == tpc_res_12) ? 16'h0FFF :
                  (res_w == tpc_res_14) ? 16'h3FFF : 16'hFFFF;

  // Opposite steps in one cycle cancel and are dropped
  assign step_ok = (state_q == tpc_st_idle) & (step_up ^ step_down);

  // One LSB up or down per accepted step
  assign cnt_step = !step_ok ? cnt_q :
                    step_up ? cnt_q + 16'h0001 :
                    cnt_q - 16'h0001;

  // Masking wraps within the selected width. A select change mid-motion
  // simply truncates the count, hence the advice to change when idle.
  assign cnt_d = cnt_step & mask_d;

  // Major carry in either direction
  assign wrap_w = step_ok & (step_up ? (cnt_q == mask_q) :
                             (cnt_q == 16'h0000));

  // Direction only moves on an actual reversal
  assign dir_flip = step_ok & (step_up != direction);
  assign dir_d = dir_flip ? step_up : direction;

  // Revolution tally follows the carry and its direction
  assign rev_d = !carry_req_q ? rev_q :
                 direction ? rev_q + 16'h0001 : rev_q - 16'h0001;

  // Counter, mask, direction and carry request
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= `TPC_POS_RST;
      mask_q <= 16'h03FF;
      direction <= `TPC_DIR_RST;
      carry_req_q <= 1'b0;
      rev_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_d;
      mask_q <= mask_d;
      direction <= dir_d;
      carry_req_q <= wrap_w;
      rev_q <= rev_d;
    end
  end

  // Carry pulse starts a cycle after direction settled; no freeze path
  tpc_pulse_gen #(
    .WIDTH(`TPC_CARRY_CYC)
  ) u_carry (
    .clock(clock),
    .rst_b(rst_b),
    .trig(carry_req_q),
    .pulse(revolution_carry_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Busy sequencer

  // Busy for a fixed width, then one idle cycle so pulses never merge
  always_comb begin
    state_d = state_q;
    left_d = left_q;
    unique case (state_q)
      tpc_st_idle: begin
        if (step_ok) begin
          state_d = tpc_st_busy;
          left_d = 2'(`TPC_BUSY_CYC - 1);
        end
      end
      tpc_st_busy: begin
        if (left_q == 2'h0) begin
          state_d = tpc_st_gap;
        end else begin
          left_d = left_q - 2'h1;
        end
      end
      tpc_st_gap: begin
        state_d = tpc_st_idle;
      end
      default: begin
        state_d = tpc_st_idle;
      end
    endcase
  end

  // State flops and busy-derived outputs
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= tpc_st_idle;
      left_q <= 2'h0;
      busy <= 1'b0;
      data_valid <= 1'b1;
      step_ready <= 1'b1;
    end else begin
      state_q <= state_d;
      left_q <= left_d;
      busy <= (state_d == tpc_st_busy);
      data_valid <= (state_d != tpc_st_busy);
      step_ready <= (state_d == tpc_st_idle);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output latch

  // Pin or software can hold the latch
  assign freeze_w = !inhibit_b | ctrl_freeze_q;

  // Count frozen cycles up to the guaranteed settling time
  assign vcnt_d = !freeze_w ? 4'h0 :
                  (vcnt_q == 4'(`TPC_VALID_CYC)) ? vcnt_q :
                  vcnt_q + 4'h1;

  // The counter is never mid-update, so the held word is always whole
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      position_word <= `TPC_POS_RST;
      vcnt_q <= 4'h0;
      latch_ready <= 1'b0;
    end else begin
      if (!freeze_w) begin
        position_word <= cnt_q;
      end
      vcnt_q <= vcnt_d;
      latch_ready <= (vcnt_d == 4'(`TPC_VALID_CYC));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register slave and interrupts

  assign wr_ctrl = reg_write & (reg_addr == `TPC_OFS_CTRL);
  assign wr_clr = reg_write & (reg_addr == `TPC_OFS_CLR);
  assign wr_en = reg_write & (reg_addr == `TPC_OFS_EN);
  assign clr_w = wr_clr ? reg_wdata[2:0] : 3'h0;

  // Events per bit position
  assign ev_w[`TPC_EV_STEP] = step_ok;
  assign ev_w[`TPC_EV_CARRY] = carry_req_q;
  assign ev_w[`TPC_EV_DIR] = dir_flip;

  tpc_irq_bank u_irq (
    .clock(clock),
    .rst_b(rst_b),
    .event_set(ev_w),
    .event_clr(clr_w),
    .status(status_w)
  );

  // Read mux; unmapped and write-only offsets read zero
  assign rd_mux =
    (reg_addr == `TPC_OFS_POS) ? {16'h0000, cnt_q} :
    (reg_addr == `TPC_OFS_CTRL) ? {31'h0, ctrl_freeze_q} :
    (reg_addr == `TPC_OFS_STAT) ? {29'h0, status_w} :
    (reg_addr == `TPC_OFS_EN) ? {29'h0, en_q} :
    (reg_addr == `TPC_OFS_REV) ? {16'h0000, rev_q} : 32'h0;

  // Control writes and one-cycle read data
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_freeze_q <= `TPC_CTRL_RST;
      en_q <= `TPC_EV_RST;
      reg_rdata <= 32'h0;
      irq <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_freeze_q <= reg_wdata[`TPC_CTRL_FREEZE];
      end
      if (wr_en) begin
        en_q <= reg_wdata[2:0];
      end
      reg_rdata <= reg_read ? rd_mux : 32'h0;
      irq <= |(status_w & en_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  a_busy_pulse_width: assert property (
    $rose(busy) |-> busy [*3] ##1 !busy
  ) else $error("busy pulse width wrong");

  a_step_one_lsb: assert property (
    step_ok && $stable(mask_d) |=>
      cnt_q == ($past(step_up) ? ($past(cnt_q) + 16'h0001) & mask_q
                               : ($past(cnt_q) - 16'h0001) & mask_q)
  ) else $error("counter did not move one step");

  a_step_busy_next: assert property (
    step_ok |=> busy
  ) else $error("step without busy pulse");

  a_wrap_carry: assert property (
    wrap_w |-> ##2 revolution_carry_out
  ) else $error("wrap gave no carry pulse");

  a_dir_before_carry: assert property (
    $rose(revolution_carry_out) |-> $stable(direction)
  ) else $error("direction moved with carry");

  a_dir_hold: assert property (
    !dir_flip |=> $stable(direction)
  ) else $error("direction changed without reversal");

  a_freeze_holds: assert property (
    freeze_w |=> $stable(position_word)
  ) else $error("latch changed while frozen");

  a_carry_in_freeze: assert property (
    wrap_w && freeze_w |-> ##2 revolution_carry_out
  ) else $error("carry lost under freeze");

  a_valid_busy: assert property (
    data_valid == !busy
  ) else $error("valid flag not inverse of busy");

  a_mask_wrap: assert property (
    (cnt_q & ~mask_q) == 16'h0000
  ) else $error("counter exceeds selected width");

  // Busy plays no part here: the settle time holds whatever its state
  a_latch_settle: assert property (
    $fell(inhibit_b) && !ctrl_freeze_q
      |-> ##[12:13] latch_ready
  ) else $error("latch not ready in time");

  // Carry shape and cause: two cycles, only after a wrap two edges back
  a_carry_width: assert property (
    $rose(revolution_carry_out) |->
      revolution_carry_out [*2] ##1 !revolution_carry_out
  ) else $error("carry pulse width wrong");

  a_carry_cause: assert property (
    $rose(revolution_carry_out) |-> $past(wrap_w, 2)
  ) else $error("carry pulse without a wrap");

  // An upward carry can only follow a roll from all ones to zero
  a_carry_up_zero: assert property (
    $rose(revolution_carry_out) && direction |-> $past(cnt_q) == 16'h0000
  ) else $error("upward carry off the zero count");

  a_dir_follows: assert property (
    step_ok |=> direction == $past(step_up)
  ) else $error("direction does not follow the step");

  // Catches a step slipping through while the sequencer is busy
  a_refused_hold: assert property (
    !step_ready && $stable(mask_d) |=> $stable(cnt_q)
  ) else $error("counter moved on a refused step");

  // Open latch copies the counter on every edge
  a_word_tracks: assert property (
    !freeze_w |=> position_word == $past(cnt_q)
  ) else $error("latch did not follow the counter");

  c_carry_up: cover property (wrap_w && step_up);
  c_carry_down: cover property (wrap_w && step_down);
  c_reversal: cover property (dir_flip);
  c_frozen_step: cover property (freeze_w && step_ok);
  c_settled_busy: cover property (latch_ready && busy);

endmodule : tpc_position_counter

// >>> testbench/tpc_host_model.sv
`timescale 1ns/1ns

// Host side: freezes the output latch and applies resolution changes
module tpc_host_model
  import tpc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic busy,
  input wire logic [15:0] position_word,
  input wire logic hold_req,
  input wire logic [1:0] res_req,
  output logic inhibit_b,
  output logic resolution_select_lo,
  output logic resolution_select_hi,
  output logic [15:0] held_word
);
  // Settle time of the latch, in cycles of the 40 ns clock
  localparam int HOLD_CYC = 12;
  logic [3:0] wait_q; // Cycles spent frozen

  //////////////////////////////////////////////////////////////////////////
  // Select follows the request only while no step is in flight
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      {resolution_select_hi, resolution_select_lo} <= 2'h0;
      inhibit_b <= 1'b1;
      wait_q <= 4'h0;
      held_word <= 16'h0000;
    end else begin
      if (!busy) begin
        {resolution_select_hi, resolution_select_lo} <= res_req;
      end
      inhibit_b <= !hold_req;
      if (inhibit_b) begin
        wait_q <= 4'h0;
      end else if (wait_q != HOLD_CYC) begin
        // Word is not taken before the settle time has run out
        wait_q <= wait_q + 4'h1;
      end else begin
        held_word <= position_word;
      end
    end
  end
endmodule : tpc_host_model

// >>> testbench/tracking_position_counter_out_tb.sv
`timescale 1ns/1ns

module tracking_position_counter_out_tb
  import tpc_pkg::*;
;
  logic clock = 0, rst_b = 0, step_up = 0, step_down = 0, hold_req = 0;
  logic [1:0] res_req = 2'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic reg_write = 0, reg_read = 0, inhibit_b, sel_lo, sel_hi;
  logic [15:0] position_word, held_word;
  logic busy, data_valid, step_ready, direction, carry, latch_ready, irq;
  int bad_count = 0, check_count = 0, exp_cnt = 0, mask = 1023;
  logic frozen = 0, carry_seen = 0; // Bench view of freeze and carry

  always #20 clock = ~clock;

  tpc_position_counter dut (.clock(clock), .rst_b(rst_b),
    .step_up(step_up), .step_down(step_down),
    .resolution_select_lo(sel_lo), .resolution_select_hi(sel_hi),
    .inhibit_b(inhibit_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .position_word(position_word), .busy(busy), .data_valid(data_valid),
    .step_ready(step_ready), .direction(direction),
    .revolution_carry_out(carry), .latch_ready(latch_ready), .irq(irq));
  tpc_host_model host (.clock(clock), .rst_b(rst_b), .busy(busy),
    .position_word(position_word), .hold_req(hold_req), .res_req(res_req),
    .inhibit_b(inhibit_b), .resolution_select_lo(sel_lo),
    .resolution_select_hi(sel_hi), .held_word(held_word));

  // Catch the carry pulse, which lasts only two cycles
  always @(negedge clock) if (carry === 1'b1) carry_seen = 1'b1;

  //////////////////////////////////////////////////////////////////////////
  task close_out;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    chk(name, exp, reg_rdata);
  endtask : rd

  // One step; a request held len cycles must still count only once
  task step(input logic up, input int len);
    int i;
    logic wrap;
    i = 0;
    @(negedge clock);
    while (step_ready !== 1'b1 && i < 20) begin
      @(negedge clock);
      i++;
    end
    if (i >= 20) begin
      chk("step_ready", 1, step_ready);
      close_out();
    end
    wrap = up ? (exp_cnt == mask) : (exp_cnt == 0);
    exp_cnt = (up ? exp_cnt + 1 : exp_cnt - 1) & mask;
    carry_seen = 1'b0;
    @(posedge clock);
    if (up) step_up <= 1'b1;
    else step_down <= 1'b1;
    i = 0;
    // Busy is counted from the taking edge, however long the request
    for (int k = 1; k <= 8; k++) begin
      @(posedge clock);
      if (k == len) begin
        step_up <= 1'b0;
        step_down <= 1'b0;
      end
      @(negedge clock);
      if (k == 1) chk("step_ready", 0, step_ready);
      if (busy === 1'b1) begin
        i++;
        chk("data_valid", 0, data_valid);
      end
    end
    chk("busy_cycles", 3, i);
    chk("direction", up, direction);
    chk("carry", wrap, carry_seen);
    if (!frozen) chk("position_word", exp_cnt, position_word);
    rd(8'h00, exp_cnt, "pos_reg");
  endtask : step

  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    @(negedge clock);
    chk("rst_busy", 0, busy);
    chk("rst_word", 0, position_word);
    chk("rst_valid", 1, data_valid);
    step(1, 3);
    step(0, 1);
    step(0, 1);
    step(1, 1);
    // Every wider resolution: wrap down to all ones and back
    for (int c = 1; c < 4; c++) begin
      @(posedge clock);
      res_req <= c[1:0];
      mask = (1 << (10 + 2 * c)) - 1;
      repeat (3) @(negedge clock);
      step(0, 1);
      step(1, 1);
    end
    // Frozen latch: count and carry go on, word stays
    @(posedge clock);
    hold_req <= 1'b1;
    frozen = 1'b1;
    repeat (16) @(negedge clock);
    chk("latch_ready", 1, latch_ready);
    chk("held_word", exp_cnt, held_word);
    step(0, 1);
    rd(8'h14, 32'hFFFF, "rev_tally");
    chk("frozen_word", 32'h0, position_word);
    @(posedge clock);
    hold_req <= 1'b0;
    frozen = 1'b0;
    repeat (4) @(negedge clock);
    chk("released_word", exp_cnt, position_word);
    chk("latch_dropped", 0, latch_ready);
    step(1, 1);
    // Software freeze holds the latch just as the pin does
    wr(8'h04, 32'h1);
    frozen = 1'b1;
    step(1, 1);
    chk("ctrl_frozen", 32'h0, position_word);
    rd(8'h04, 32'h1, "ctrl_reg");
    wr(8'h04, 32'h0);
    frozen = 1'b0;
    repeat (2) @(negedge clock);
    chk("ctrl_released", exp_cnt, position_word);
    // Sticky status, enable, clear, unmapped place
    rd(8'h08, 32'h7, "status");
    wr(8'h10, 32'h2);
    repeat (3) @(negedge clock);
    chk("irq_on", 1, irq);
    wr(8'h0C, 32'h2);
    repeat (3) @(negedge clock);
    chk("irq_off", 0, irq);
    rd(8'h08, 32'h5, "status_cleared");
    rd(8'h40, 32'h0, "unmapped");
    close_out();
  end
endmodule : tracking_position_counter_out_tb
